// ---- verilog/ftr_pkg.sv ----
// shared constants and types for the flash timing, thermistor and flag regs
package ftr_pkg;
   // register offsets on the internal register port
   localparam logic [7:0] OFF_TIMING = 8'h08;
   localparam logic [7:0] OFF_THERM = 8'h09;
   localparam logic [7:0] OFF_FAULT_FLAGS_PRIMARY = 8'h0a;
   localparam logic [7:0] OFF_FAULT_FLAGS_SECONDARY = 8'h0b;
   localparam logic [7:0] OFF_IDENT = 8'h0c;
   // values after reset
   localparam logic [7:0] RST_TIMING = 8'h1a;
   localparam logic [7:0] RST_THERM = 8'h08;
   // writable bits, reserved bits read as zero
   localparam logic [7:0] MASK_TIMING = 8'h7f;
   localparam logic [7:0] MASK_THERM = 8'h7f;
   // field positions
   localparam int RAMP_LSB = 4;
   localparam int TOUT_LSB = 0;
   localparam int POL_BIT = 6;
   localparam int OPEN_EN_BIT = 5;
   localparam int SHORT_EN_BIT = 4;
   localparam int THR_LSB = 1;
   localparam int FUNC_BIT = 0;
   localparam int F1_TOUT_BIT = 0;
   localparam int F1_TSD_BIT = 2;
   localparam int F2_OPEN_BIT = 3;
   localparam int F2_SHORT_BIT = 4;
   localparam int ID_LSB = 3;
   // clock rate and derived cycle counts
   localparam int CLK_PERIOD_NS = 8;
   localparam int MS_NS = 1000000;
   localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
   localparam int RAMP_STEPS = 128;
   localparam int TMR_W = 26;

   typedef enum logic [1:0] {
      MODE_STANDBY = 2'h0,
      MODE_IR = 2'h1,
      MODE_TORCH = 2'h2,
      MODE_FLASH = 2'h3
   } ftr_mode_t;

   typedef enum logic [2:0] {
      RAMP_IDLE = 3'h1,
      RAMP_RUN = 3'h2,
      RAMP_HOLD = 3'h4
   } ftr_ramp_st_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ftr_req_t;

   typedef struct packed {
      logic [7:0] prim;
      logic [4:0] sec;
   } ftr_fault_t;

   // torch ramp time in ms; code 0 means no ramp
   function automatic int ramp_ms(input logic [2:0] code);
      int r;
      r = 0;
      if (code == 3'h1) begin
         r = 1;
      end else if (code != 3'h0) begin
         r = 32 << (code - 3'h2);
      end
      return r;
   endfunction : ramp_ms

   // flash time-out in ms
   function automatic int tout_ms(input logic [3:0] code);
      int r;
      r = 0;
      if (code <= 4'h9) begin
         r = 10 * (code + 1);
      end else begin
         r = 150 + 50 * (code - 4'ha);
      end
      return r;
   endfunction : tout_ms
endpackage : ftr_pkg

// ---- verilog/ftr_down_timer.sv ----
// loadable down counter that pulses once when it runs out
`timescale 1ns/1ps
module ftr_down_timer #(
   parameter int W = 26
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   // control
   input wire logic load_i,
   input wire logic [W-1:0] value_i,
   input wire logic run_i,
   // status
   output logic done_o
);
   logic [W-1:0] cnt_q, cnt_d;
   logic done_q, done_d;

   always_comb begin
      cnt_d = cnt_q;
      done_d = 1'b0;
      if (load_i) begin
         cnt_d = value_i;
      end else if (run_i && cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
         done_d = (cnt_q == W'(1));
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_q <= '0;
         done_q <= 1'b0;
      end else if (ce_i) begin
         cnt_q <= cnt_d;
         done_q <= done_d;
      end
   end

   assign done_o = done_q;
endmodule : ftr_down_timer

// ---- verilog/ftr_regs.sv ----
// timing, thermistor, flag and identity registers of the flash driver
// Notes on behaviour
// - ramp field bits 6:4; 0 no ramp, 1 is 1 ms, then 32..1024 ms
// - thermal shutdown ends a flash before its time-out runs out
// - polarity bit 6: 0 active high with pulldown, 1 active low without
// - polarity held fixed outside standby; host changes it only in standby
// - thermistor open bit 5 and short bit 4 enable detection, default off
// - detect threshold bits 3:1, 0.2 V to 0.9 V, default code 100
// - pin function bit 0: 0 torch input, 1 thermistor monitoring
// - first flag register: sync, boost short, led shorts, limit, tsd, uv, tout
// - second flag register: reserved 7:5, short, open, monitor, ovp, temp
// - read-only identity: reserved 7:6, identity_revision 5:3, revision 2:0
// - mode 00 standby, 01 infrared, 10 torch, 11 flash
`timescale 1ns/1ps
module ftr_regs #(
   parameter int CYC_PER_MS = ftr_pkg::CYC_PER_MS,
   // arbitrary neutral identity values
   parameter logic [2:0] DEV_ID = 3'h5,
   parameter logic [2:0] SI_REV = 3'h3
) (
   // clock, reset, enable
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   // register port from the serial engine
   input wire ftr_pkg::ftr_req_t req_i,
   output logic [7:0] rdata_o,
   // unit side
   input wire logic [1:0] mode_i,
   input wire logic [6:0] torch_target_i,
   output logic [6:0] torch_level_o,
   output logic flash_stop_o,
   // pins and analog detectors, asynchronous
   input wire logic torch_pin_i,
   input wire ftr_pkg::ftr_fault_t fault_i,
   // analog and pad controls
   output logic pulldown_en_o,
   output logic torch_req_o,
   output logic therm_mon_o,
   output logic open_det_en_o,
   output logic short_det_en_o,
   output logic [2:0] therm_thr_o
);
   logic [7:0] timing_q, timing_d, therm_q, therm_d;
   logic [7:0] fault_flags_primary_q, fault_flags_primary_d, rdata_q, rdata_d;
   logic [4:0] fault_flags_secondary_q, fault_flags_secondary_d;
   logic pol_q, pol_d;
   ftr_pkg::ftr_fault_t flt_m_q, flt_s_q;
   logic pin_m_q, pin_s_q, tsd_prev_q;
   logic [1:0] mode_prev_q;
   logic [7:0] f1_set, f2_set;
   logic rd_f1, rd_f2, tout_done, step_done;

   assign rd_f1 = req_i.rd && req_i.addr == ftr_pkg::OFF_FAULT_FLAGS_PRIMARY;
   assign rd_f2 = req_i.rd && req_i.addr == ftr_pkg::OFF_FAULT_FLAGS_SECONDARY;

   // pins pass two flops; the first is read by the second only
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flt_m_q <= '0;
         flt_s_q <= '0;
         pin_m_q <= 1'b0;
         pin_s_q <= 1'b0;
         tsd_prev_q <= 1'b0;
         mode_prev_q <= ftr_pkg::MODE_STANDBY;
      end else if (ce_i) begin
         flt_m_q <= fault_i;
         flt_s_q <= flt_m_q;
         pin_m_q <= torch_pin_i;
         pin_s_q <= pin_m_q;
         tsd_prev_q <= flt_s_q.prim[ftr_pkg::F1_TSD_BIT];
         mode_prev_q <= mode_i;
      end
   end

   always_comb begin
      timing_d = timing_q;
      therm_d = therm_q;
      pol_d = pol_q;
      rdata_d = rdata_q;
      f1_set = flt_s_q.prim;
      f1_set[ftr_pkg::F1_TOUT_BIT] = tout_done;
      // thermistor faults only when detection is enabled
      f2_set = {3'h0, flt_s_q.sec};
      f2_set[ftr_pkg::F2_OPEN_BIT] = flt_s_q.sec[ftr_pkg::F2_OPEN_BIT]
         & therm_q[ftr_pkg::OPEN_EN_BIT];
      f2_set[ftr_pkg::F2_SHORT_BIT] = flt_s_q.sec[ftr_pkg::F2_SHORT_BIT]
         & therm_q[ftr_pkg::SHORT_EN_BIT];
      // clear on read, a new set wins
      fault_flags_primary_d = (rd_f1 ? 8'h00 : fault_flags_primary_q) | f1_set;
      fault_flags_secondary_d = (rd_f2 ? 5'h00 : fault_flags_secondary_q) | f2_set[4:0];
      if (req_i.wr && req_i.addr == ftr_pkg::OFF_TIMING) begin
         timing_d = req_i.wdata & ftr_pkg::MASK_TIMING;
      end
      if (req_i.wr && req_i.addr == ftr_pkg::OFF_THERM) begin
         therm_d = req_i.wdata & ftr_pkg::MASK_THERM;
      end
      // polarity copy follows only in standby
      if (mode_i == ftr_pkg::MODE_STANDBY) begin
         pol_d = therm_d[ftr_pkg::POL_BIT];
      end
      if (req_i.rd) begin
         unique case (req_i.addr)
            ftr_pkg::OFF_TIMING: rdata_d = timing_q;
            ftr_pkg::OFF_THERM: rdata_d = therm_q;
            ftr_pkg::OFF_FAULT_FLAGS_PRIMARY: rdata_d = fault_flags_primary_q;
            ftr_pkg::OFF_FAULT_FLAGS_SECONDARY: rdata_d = {3'h0, fault_flags_secondary_q};
            ftr_pkg::OFF_IDENT: rdata_d = {2'h0, DEV_ID, SI_REV};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         timing_q <= ftr_pkg::RST_TIMING;
         therm_q <= ftr_pkg::RST_THERM;
         pol_q <= 1'b0;
         fault_flags_primary_q <= 8'h00;
         fault_flags_secondary_q <= 5'h00;
         rdata_q <= 8'h00;
      end else if (ce_i) begin
         timing_q <= timing_d;
         therm_q <= therm_d;
         pol_q <= pol_d;
         fault_flags_primary_q <= fault_flags_primary_d;
         fault_flags_secondary_q <= fault_flags_secondary_d;
         rdata_q <= rdata_d;
      end
   end

   // polarity steers pulldown and input sense
   assign pulldown_en_o = !pol_q;
   // torch request only when the pin works as torch input
   assign torch_req_o = !therm_q[ftr_pkg::FUNC_BIT] && (pin_s_q ^ pol_q);
   assign therm_mon_o = therm_q[ftr_pkg::FUNC_BIT];
   assign open_det_en_o = therm_q[ftr_pkg::OPEN_EN_BIT];
   assign short_det_en_o = therm_q[ftr_pkg::SHORT_EN_BIT];
   assign therm_thr_o = therm_q[ftr_pkg::THR_LSB +: 3];
   assign rdata_o = rdata_q;

   // flash and torch sequencing
   ftr_pkg::ftr_ramp_st_t st_q, st_d;
   logic [6:0] lvl_q, lvl_d;
   logic stop_q, stop_d, fl_entry, tq_entry, tsd_rise, in_flash;
   logic [ftr_pkg::TMR_W-1:0] tout_cyc, step_cyc, step_load;

   assign in_flash = mode_i == ftr_pkg::MODE_FLASH;
   assign fl_entry = in_flash && mode_prev_q != ftr_pkg::MODE_FLASH;
   assign tq_entry = mode_i == ftr_pkg::MODE_TORCH
      && mode_prev_q != ftr_pkg::MODE_TORCH;
   assign tsd_rise = flt_s_q.prim[ftr_pkg::F1_TSD_BIT] && !tsd_prev_q;
   assign tout_cyc = ftr_pkg::TMR_W'(ftr_pkg::tout_ms(
      timing_q[ftr_pkg::TOUT_LSB +: 4]) * CYC_PER_MS);
   // one ramp step lasts a share of the ramp time
   assign step_cyc = ftr_pkg::TMR_W'(ftr_pkg::ramp_ms(
      timing_q[ftr_pkg::RAMP_LSB +: 3]) * CYC_PER_MS / ftr_pkg::RAMP_STEPS);
   // reload one short: the reload edge is itself a cycle of the step
   assign step_load = (step_cyc > ftr_pkg::TMR_W'(1)) ? step_cyc - 1'b1
      : step_cyc;

   ftr_down_timer #(.W(ftr_pkg::TMR_W)) u_tout (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .load_i(fl_entry),
      .value_i(tout_cyc),
      .run_i(in_flash),
      .done_o(tout_done)
   );

   ftr_down_timer #(.W(ftr_pkg::TMR_W)) u_step (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .load_i(tq_entry || (st_q == ftr_pkg::RAMP_RUN && step_done)),
      .value_i(step_load),
      .run_i(st_q == ftr_pkg::RAMP_RUN),
      .done_o(step_done)
   );

   always_comb begin
      st_d = st_q;
      lvl_d = lvl_q;
      // thermal shutdown ends the flash early
      stop_d = in_flash && (tout_done || tsd_rise);
      if (mode_i != ftr_pkg::MODE_TORCH) begin
         st_d = ftr_pkg::RAMP_IDLE;
         lvl_d = 7'h00;
      end else begin
         unique case (st_q)
            // ramp from zero, or at once with no ramp
            ftr_pkg::RAMP_IDLE: begin
               if (timing_q[ftr_pkg::RAMP_LSB +: 3] == 3'h0) begin
                  st_d = ftr_pkg::RAMP_HOLD;
                  lvl_d = torch_target_i;
               end else begin
                  st_d = ftr_pkg::RAMP_RUN;
                  lvl_d = 7'h00;
               end
            end
            ftr_pkg::RAMP_RUN: begin
               if (lvl_q >= torch_target_i) begin
                  st_d = ftr_pkg::RAMP_HOLD;
                  lvl_d = torch_target_i;
               end else if (step_done) begin
                  lvl_d = lvl_q + 7'h01;
               end
            end
            ftr_pkg::RAMP_HOLD: lvl_d = torch_target_i;
            default: begin
               st_d = ftr_pkg::RAMP_IDLE;
               lvl_d = 7'h00;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q <= ftr_pkg::RAMP_IDLE;
         lvl_q <= 7'h00;
         stop_q <= 1'b0;
      end else if (ce_i) begin
         st_q <= st_d;
         lvl_q <= lvl_d;
         stop_q <= stop_d;
      end
   end

   assign torch_level_o = lvl_q;
   assign flash_stop_o = stop_q;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_id_read;
      ce_i && req_i.rd && req_i.addr == ftr_pkg::OFF_IDENT;
   endsequence

   a_ident_value: assert property (
      s_id_read |=> rdata_o == {2'h0, DEV_ID, SI_REV})
      else $error("identity read wrong");
   a_unmapped_zero: assert property (
      ce_i && req_i.rd && req_i.addr > ftr_pkg::OFF_IDENT |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_timing_write: assert property (
      ce_i && req_i.wr && req_i.addr == ftr_pkg::OFF_TIMING
      |=> timing_q == ($past(req_i.wdata) & ftr_pkg::MASK_TIMING))
      else $error("timing write lost");
   a_pol_fixed: assert property (
      mode_i != ftr_pkg::MODE_STANDBY |=> $stable(pol_q))
      else $error("polarity moved outside standby");
   a_pulldown_pol: assert property (
      pulldown_en_o == !pol_q)
      else $error("pulldown disagrees with polarity");
   a_flag_sticky: assert property (
      ce_i && !rd_f1 |=> (fault_flags_primary_q & $past(fault_flags_primary_q)) == $past(fault_flags_primary_q))
      else $error("flag dropped without read");
   a_tout_flag: assert property (
      ce_i && tout_done |=> fault_flags_primary_q[ftr_pkg::F1_TOUT_BIT] && flash_stop_o)
      else $error("time-out did not flag and stop");
   a_tsd_stop: assert property (
      ce_i && in_flash && tsd_rise |=> flash_stop_o)
      else $error("thermal shutdown did not stop flash");
   a_ramp_none: assert property (
      ce_i && st_q == ftr_pkg::RAMP_IDLE && mode_i == ftr_pkg::MODE_TORCH
      && timing_q[6:4] == 3'h0 |=> st_q == ftr_pkg::RAMP_HOLD)
      else $error("no-ramp code did not apply at once");
endmodule : ftr_regs

// ---- tb/ftr_host_model.sv ----
// host model driving the register port one byte at a time
`timescale 1ns/1ps
module ftr_host_model (
   // clock
   input wire logic ref_clk_i,
   // register port
   output ftr_pkg::ftr_req_t req_o,
   input wire logic [7:0] rdata_i
);
   initial req_o = '0;

   // polarity changes belong in standby; one test breaks this on purpose
   task automatic do_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk_i);
      req_o.wr <= 1'b0;
   endtask : do_wr

   // data lands one cycle after the strobe edge and holds until next read
   task automatic do_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge ref_clk_i);
      req_o.rd <= 1'b0;
      #1;
      d = rdata_i;
   endtask : do_rd
endmodule : ftr_host_model

// ---- tb/tb_flash_timing_temp_flag_regs.sv ----
// self-checking bench for the flash timing, thermistor and flag registers
`timescale 1ns/1ps
module tb_flash_timing_temp_flag_regs;
   // large enough that a ramp step is two cycles
   localparam int CPM = 256;
   // arbitrary identity values
   localparam logic [2:0] DID = 3'h6;
   localparam logic [2:0] REV = 3'h1;
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic ce = 1'b1;
   logic [1:0] mode = 2'h0;
   logic [6:0] tgt = 7'h00;
   logic pin = 1'b0;
   ftr_pkg::ftr_fault_t flt = '0;
   ftr_pkg::ftr_req_t req;
   logic [7:0] rdata;
   logic [6:0] level;
   logic stop, pd_en, treq, tmon, open_en, short_en;
   logic [2:0] thr;
   int n_mismatch = 0;
   int n_checks = 0;
   logic [31:0] seed = 32'he9a83c13;

   always #4 ref_clk_i = ~ref_clk_i;

   ftr_regs #(.CYC_PER_MS(CPM), .DEV_ID(DID), .SI_REV(REV)) i_dut (
      .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce),
      .req_i(req), .rdata_o(rdata), .mode_i(mode),
      .torch_target_i(tgt), .torch_level_o(level), .flash_stop_o(stop),
      .torch_pin_i(pin), .fault_i(flt), .pulldown_en_o(pd_en),
      .torch_req_o(treq), .therm_mon_o(tmon), .open_det_en_o(open_en),
      .short_det_en_o(short_en), .therm_thr_o(thr));

   ftr_host_model i_host (.ref_clk_i(ref_clk_i), .req_o(req),
      .rdata_i(rdata));

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   // expected flash time-out in cycles
   function automatic int tout_cyc(input int c);
      return (c <= 9 ? 10 * (c + 1) : 150 + 50 * (c - 10)) * CPM;
   endfunction : tout_cyc

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      i_host.do_rd(a, d);
      check(d, e);
   endtask : rchk

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : cyc

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   // one flash; returns cycles from mode change to the stop pulse
   task automatic flash(output int n);
      @(posedge ref_clk_i) mode <= 2'h3;
      n = 0;
      while (stop !== 1'b1 && n < 12000) begin
         cyc(1);
         n++;
      end
      @(posedge ref_clk_i) mode <= 2'h0;
   endtask : flash

   initial begin
      repeat (40000) @(posedge ref_clk_i);
      n_mismatch++;
      final_report();
   end

   initial begin
      logic [7:0] w;
      logic [7:0] o;
      logic [31:0] r;
      int n;
      repeat (8) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      cyc(1);
      check({open_en, short_en, tmon, pd_en, 1'b0, thr}, 8'h14);
      rchk(8'h08, 8'h1a); // timing reset
      rchk(8'h09, 8'h08); // thermistor reset
      rchk(8'h0a, 8'h00); // flags clear
      rchk(8'h0b, 8'h00); // flags clear
      i_host.do_wr(8'h0c, 8'hff);
      rchk(8'h0c, {2'b00, DID, REV}); // read-only
      rchk(8'h0d, 8'h00); // unmapped
      for (int i = 0; i < 10; i++) begin
         r = xs();
         w = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : r[7:0];
         i_host.do_wr(8'h08, w);
         rchk(8'h08, w & 8'h7f); // fields
         i_host.do_wr(8'h09, w);
         rchk(8'h09, w & 8'h7f); // fields
         o = {1'b0, pd_en, open_en, short_en, thr, tmon};
         check(o, {1'b0, ~w[6], w[5:0]});
      end
      // enable low freezes the bank, reset restores it
      @(posedge ref_clk_i) ce <= 1'b0;
      i_host.do_wr(8'h08, ~w);
      @(posedge ref_clk_i) ce <= 1'b1;
      rchk(8'h08, w & 8'h7f); // frozen by enable
      @(posedge ref_clk_i) rstn_i <= 1'b0;
      cyc(2);
      @(posedge ref_clk_i) rstn_i <= 1'b1;
      rchk(8'h08, 8'h1a); // reset in mid-run
      rchk(8'h09, 8'h08); // reset in mid-run
      for (int i = 0; i < 4; i++) begin
         i_host.do_wr(8'h09, {1'b0, i[1], 6'h00});
         @(posedge ref_clk_i) pin <= i[0];
         cyc(4);
         check({7'h0, treq}, {7'h0, i[0] ^ i[1]}); // pin sense
      end
      i_host.do_wr(8'h09, 8'h01);
      cyc(1);
      check({7'h0, treq}, 8'h00); // pin as monitor
      @(posedge ref_clk_i) mode <= 2'h1;
      i_host.do_wr(8'h09, 8'h41);
      cyc(2);
      check({7'h0, pd_en}, 8'h01); // frozen
      @(posedge ref_clk_i) mode <= 2'h0;
      cyc(2);
      check({7'h0, pd_en}, 8'h00); // applied
      i_host.do_wr(8'h09, 8'h30);
      for (int i = 0; i < 3; i++) begin
         r = xs();
         @(posedge ref_clk_i) flt <= r[12:0];
         cyc(4);
         @(posedge ref_clk_i) flt <= '0;
         cyc(4);
         rchk(8'h0a, {r[12:6], 1'b0}); // primary
         rchk(8'h0b, {3'h0, r[4:0]}); // secondary
         rchk(8'h0a, 8'h00); // cleared
         rchk(8'h0b, 8'h00); // cleared
      end
      i_host.do_wr(8'h09, 8'h00);
      @(posedge ref_clk_i) flt.sec <= 5'h18;
      cyc(4);
      @(posedge ref_clk_i) flt <= '0;
      cyc(4);
      rchk(8'h0b, 8'h00); // detection off
      // torch entry with and without ramp
      @(posedge ref_clk_i) tgt <= 7'h14;
      i_host.do_wr(8'h08, 8'h00);
      @(posedge ref_clk_i) mode <= 2'h2;
      cyc(4);
      check({1'b0, level}, 8'h14); // no ramp
      @(posedge ref_clk_i) mode <= 2'h0;
      cyc(2);
      check({1'b0, level}, 8'h00); // off
      i_host.do_wr(8'h08, 8'h10);
      @(posedge ref_clk_i) mode <= 2'h2;
      cyc(4);
      check({7'h0, level < 7'h14}, 8'h01); // ramping
      // 1 ms in 128 steps is two cycles a step: 20 steps take 40 cycles
      cyc(38);
      check({1'b0, level}, 8'h14); // ramp done in time
      @(posedge ref_clk_i) mode <= 2'h0;
      // time-out length per code, flag raised
      for (int c = 0; c < 2; c++) begin
         i_host.do_wr(8'h08, c[7:0]);
         flash(n);
         o = {7'h0, n >= tout_cyc(c) && n <= tout_cyc(c) + 5};
         check(o, 8'h01); // time-out length
         rchk(8'h0a, 8'h01); // time-out flag
      end
      i_host.do_wr(8'h08, 8'h0f);
      fork
         flash(n);
         begin
            cyc(10);
            @(posedge ref_clk_i) flt.prim[2] <= 1'b1;
         end
      join
      check({7'h0, n <= 18}, 8'h01); // early stop
      @(posedge ref_clk_i) flt <= '0;
      cyc(4);
      rchk(8'h0a, 8'h04); // shutdown flag
      final_report();
   end
endmodule : tb_flash_timing_temp_flag_regs
